// File: t1flp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module t1flp_line_model
   import t1flp_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire t1flp_bit_t tx_link_in,
   output t1flp_bit_t      rx_link_out,
   output logic            tx_req_out,
   output logic            tx_mf_out
);
   import t1flp_pkg::*;
   initial
   begin
      rx_link_out = '0;
      tx_req_out = 1'b0;
      tx_mf_out = 1'b0;
   end
   // line bits in arrival order, first bit is v[0]
   task automatic send_bits(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk_in);
         rx_link_out <= '{strobe: 1'b1, value: v[i]};
      end
      @(posedge mclk_in);
      // idle line shows the inverse so a stale bit is never mistaken for data
      rx_link_out <= '{strobe: 1'b0, value: ~v[n-1]};
   endtask
   task automatic pull_bits(input int n, output logic [15:0] got);
      got = '0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk_in);
         tx_req_out <= 1'b1;
         @(posedge mclk_in);
         tx_req_out <= 1'b0;
         @(posedge mclk_in);
         got[i] = tx_link_in.value;
      end
   endtask
   task automatic mf_pulse();
      @(posedge mclk_in);
      tx_mf_out <= 1'b1;
      @(posedge mclk_in);
      tx_mf_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: t1flp_link_port.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module t1flp_link_port
   import t1flp_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              sys_rst_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [DATA_W-1:0] rdata_out,
   input  wire t1flp_bit_t        rx_link_in,
   input  wire logic              tx_req_in,
   input  wire logic              tx_mf_boundary_in,
   output t1flp_bit_t             tx_link_out,
   output logic                   tx_fs_from_byte_out,
   output logic                   int_n_out
);
   import t1flp_pkg::*;

   localparam logic [2:0] RUN_FIVE = 3'(STUFF_RUN);
   localparam logic [3:0] LAST_BIT = 4'(BITS_PER_BYTE - 1);

   logic [7:0] receive_link_byte;
   logic [7:0] transmit_link_byte;
   logic [7:0] receive_link_match_one;
   logic [7:0] receive_link_match_two;
   logic [7:0] link_status_flags;
   logic [7:0] link_interrupt_mask;
   logic [7:0] t1_receive_control_two;
   logic [7:0] t1_transmit_control_two;
   logic [7:0] t1_transmit_control_one;
   logic [7:0] rdata;

   logic [7:0] next_transmit_link_byte;
   logic [7:0] next_match_one;
   logic [7:0] next_match_two;
   logic [7:0] next_status;
   logic [7:0] next_mask;
   logic [7:0] next_rc2;
   logic [7:0] next_tc2;
   logic [7:0] next_tc1;
   logic [7:0] next_rdata;
   logic [7:0] flag_event;
   logic [7:0] flag_clear;

   logic [7:0] rx_shift;
   logic [3:0] rx_count;
   logic [7:0] next_receive_link_byte;
   logic [7:0] next_rx_shift;
   logic [3:0] next_rx_count;
   logic       rx_done;
   logic       rx_match;

   logic [7:0] tx_shift;
   logic [3:0] tx_count;
   logic       tx_bit;
   logic       tx_strobe;
   logic [7:0] next_tx_shift;
   logic [3:0] next_tx_count;
   logic       next_tx_bit;
   logic       next_tx_strobe;
   logic       tx_done;
   logic       tx_step;

   logic [2:0] rx_run;
   logic [2:0] tx_run;
   logic       rx_drop;
   logic       tx_stuff;
   logic [7:0] tx_cur;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // run of ones seen on the received link
   t1flp_ones_run #(
      .RUN_W (3)
   ) u_rx_run (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .step_in    (rx_link_in.strobe),
      .bit_in     (rx_link_in.value),
      .run_out    (rx_run)
   );

   // run of ones already sent on the transmit link, stuffed zeros included
   t1flp_ones_run #(
      .RUN_W (3)
   ) u_tx_run (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .step_in    (tx_req_in),
      .bit_in     (next_tx_bit),
      .run_out    (tx_run)
   );

   // receive deserialiser
   always_comb
   begin
      rx_drop = t1_receive_control_two[RC2_DESTUFF] && rx_link_in.strobe
                && !rx_link_in.value && (rx_run == RUN_FIVE);          // [RL6] [RL7]
      next_rx_shift          = rx_shift;
      next_rx_count          = rx_count;
      next_receive_link_byte = receive_link_byte;
      rx_done                = 1'b0;
      if (rx_link_in.strobe && !rx_drop)
      begin
         next_rx_shift = {rx_link_in.value, rx_shift[7:1]};           // [RL1] [RL15]
         if (rx_count == LAST_BIT)
         begin
            next_rx_count          = '0;
            next_receive_link_byte = next_rx_shift;                   // [RL2]
            rx_done                = 1'b1;
         end
         else
         begin
            next_rx_count = rx_count + 4'h1;
         end
      end
      rx_match = rx_done && ((next_rx_shift == receive_link_match_one)
                 || (next_rx_shift == receive_link_match_two));       // [RL5]
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         rx_shift          <= RESET_BYTE;
         rx_count          <= '0;
         receive_link_byte <= RESET_BYTE;
      end
      else
      begin
         rx_shift          <= next_rx_shift;
         rx_count          <= next_rx_count;
         // unread byte is simply overwritten, host must keep up
         receive_link_byte <= next_receive_link_byte;                 // [RL4]
      end
   end

   // transmit serialiser
   always_comb
   begin
      // byte boundary takes a fresh copy, or the old byte again
      tx_cur   = (tx_count == '0) ? transmit_link_byte : tx_shift;    // [RL16] [RL11]
      tx_stuff = t1_transmit_control_two[TC2_STUFF] && (tx_run == RUN_FIVE);  // [RL12]
      tx_step  = tx_req_in && !tx_stuff;
      next_tx_shift  = tx_shift;
      next_tx_count  = tx_count;
      next_tx_bit    = tx_bit;
      next_tx_strobe = tx_req_in;
      tx_done        = 1'b0;
      if (tx_req_in)
      begin
         next_tx_bit = tx_stuff ? 1'b0 : tx_cur[0];                   // [RL9] [RL15]
      end
      if (tx_step)
      begin
         next_tx_shift = {1'b0, tx_cur[7:1]};
         if (tx_count == LAST_BIT)
         begin
            next_tx_count = '0;
            tx_done       = 1'b1;                                     // [RL10]
         end
         else
         begin
            next_tx_count = tx_count + 4'h1;
         end
      end
      // boundary load realigns the byte to the multiframe for Fs insertion
      if (t1_transmit_control_two[TC2_MFLOAD] && tx_mf_boundary_in && !tx_step)
      begin
         next_tx_count = '0;                                          // [RL14]
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         tx_shift  <= RESET_BYTE;
         tx_count  <= '0;
         tx_bit    <= 1'b0;
         tx_strobe <= 1'b0;
      end
      else
      begin
         tx_shift  <= next_tx_shift;
         tx_count  <= next_tx_count;
         tx_bit    <= next_tx_bit;
         tx_strobe <= next_tx_strobe;
      end
   end

   // configuration registers, reserved bits masked on the way in
   always_comb
   begin
      next_transmit_link_byte = transmit_link_byte;
      next_match_one          = receive_link_match_one;
      next_match_two          = receive_link_match_two;
      next_mask               = link_interrupt_mask;
      next_rc2                = t1_receive_control_two;
      next_tc2                = t1_transmit_control_two;
      next_tc1                = t1_transmit_control_one;
      if (wr_in)
      begin
         if (hit(addr_in, REG_TX_BYTE))
            next_transmit_link_byte = wdata_in;
         if (hit(addr_in, REG_MATCH_ONE))
            next_match_one = wdata_in;
         if (hit(addr_in, REG_MATCH_TWO))
            next_match_two = wdata_in;
         if (hit(addr_in, REG_MASK))
            next_mask = wdata_in & FLAG_MASK;
         if (hit(addr_in, REG_RX_CTRL2))
            next_rc2 = wdata_in & RC2_MASK;                           // [RL8]
         if (hit(addr_in, REG_TX_CTRL2))
            next_tc2 = wdata_in & TC2_MASK;                           // [RL13]
         if (hit(addr_in, REG_TX_CTRL1))
            next_tc1 = wdata_in & TC1_MASK;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         transmit_link_byte      <= RESET_BYTE;
         receive_link_match_one  <= RESET_BYTE;
         receive_link_match_two  <= RESET_BYTE;
         link_interrupt_mask     <= RESET_BYTE;
         t1_receive_control_two  <= RESET_BYTE;
         t1_transmit_control_two <= RESET_BYTE;
         t1_transmit_control_one <= RESET_BYTE;
      end
      else
      begin
         transmit_link_byte      <= next_transmit_link_byte;
         receive_link_match_one  <= next_match_one;
         receive_link_match_two  <= next_match_two;
         link_interrupt_mask     <= next_mask;
         t1_receive_control_two  <= next_rc2;
         t1_transmit_control_two <= next_tc2;
         t1_transmit_control_one <= next_tc1;
      end
   end

   // one event line per status bit, the unused bits are never set
   always_comb
   begin
      flag_event             = '0;
      flag_event[ST_RXFULL]  = rx_done;                               // [RL2]
      flag_event[ST_MATCH]   = rx_match;                              // [RL5]
      flag_event[ST_TXEMPTY] = tx_done;                               // [RL10]
      flag_clear             = '0;
      if (wr_in && hit(addr_in, REG_STATUS))
         flag_clear = wdata_in;
   end

   // set wins so an event in the clearing cycle is not lost
   for (genvar i = 0; i < DATA_W; i++)
   begin : g_flag
      assign next_status[i] = flag_event[i] | (link_status_flags[i] & ~flag_clear[i]);
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         link_status_flags <= RESET_BYTE;
      else
         link_status_flags <= next_status;
   end

   // read answer stands one cycle, zero otherwise
   always_comb
   begin
      next_rdata = '0;
      if (rd_in)
      begin
         unique case (addr_in)
            REG_RX_BYTE:   next_rdata = receive_link_byte;
            REG_TX_BYTE:   next_rdata = transmit_link_byte;
            REG_MATCH_ONE: next_rdata = receive_link_match_one;
            REG_MATCH_TWO: next_rdata = receive_link_match_two;
            REG_STATUS:    next_rdata = link_status_flags;
            REG_MASK:      next_rdata = link_interrupt_mask;
            REG_RX_CTRL2:  next_rdata = t1_receive_control_two;
            REG_TX_CTRL2:  next_rdata = t1_transmit_control_two;
            REG_TX_CTRL1:  next_rdata = t1_transmit_control_one;
            default:       next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         rdata <= RESET_BYTE;
      else
         rdata <= next_rdata;
   end

   assign rdata_out          = rdata;
   assign tx_link_out.strobe = tx_strobe;
   assign tx_link_out.value  = tx_bit;
   // cleared select means Fs comes from the transmit byte
   assign tx_fs_from_byte_out = ~t1_transmit_control_one[TC1_FS_SRC]; // [RL14]
   assign int_n_out = ~|(link_status_flags & link_interrupt_mask);    // [RL3] [RL5] [RL10]
endmodule
`default_nettype wire

// File: t1flp_link_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module t1flp_link_port_sva
   import t1flp_pkg::*;
(
   input wire logic              mclk_in,
   input wire logic              sys_rst_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire t1flp_bit_t        rx_link_in,
   input wire logic              tx_req_in,
   input wire logic              tx_mf_boundary_in,
   input wire t1flp_bit_t        tx_link_out,
   input wire logic              tx_fs_from_byte_out,
   input wire logic              int_n_out
);
   import t1flp_pkg::*;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   chk_tx_bit_answer: assert property (tx_req_in |=> tx_link_out.strobe)
      else $error("no transmit bit after request");
   chk_tx_bit_only: assert property (!tx_req_in |=> !tx_link_out.strobe)
      else $error("transmit bit without request");
   chk_tx_value_hold: assert property (!tx_req_in |=> $stable(tx_link_out.value))
      else $error("transmit bit changed without request");
   chk_rdata_idle: assert property (!rd_in |=> rdata_out == '0)
      else $error("read data outside read answer");
   chk_unmapped_zero: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == '0)
      else $error("unmapped read not zero");
   chk_int_masked_off: assert property (wr_in && addr_in == REG_MASK && wdata_in == '0
      |=> int_n_out)
      else $error("interrupt low with all masked");
   chk_int_no_cause: assert property (!wr_in && !rx_link_in.strobe && !tx_req_in
      |=> $stable(int_n_out))
      else $error("interrupt moved without event");
   chk_fs_src_write: assert property (wr_in && addr_in == REG_TX_CTRL1
      |=> tx_fs_from_byte_out == !$past(wdata_in[TC1_FS_SRC]))
      else $error("fs source select wrong");
   chk_fs_src_hold: assert property (!wr_in |=> $stable(tx_fs_from_byte_out))
      else $error("fs source moved without write");
   cov_rx_one: cover property (rx_link_in.strobe && rx_link_in.value);
   cov_int_low: cover property (!int_n_out);
   cov_mf: cover property (tx_mf_boundary_in);
endmodule
bind t1flp_link_port t1flp_link_port_sva u_t1flp_link_port_sva (.mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .rx_link_in(rx_link_in), .tx_req_in(tx_req_in),
   .tx_mf_boundary_in(tx_mf_boundary_in), .tx_link_out(tx_link_out),
   .tx_fs_from_byte_out(tx_fs_from_byte_out), .int_n_out(int_n_out));
`default_nettype wire

// File: t1flp_ones_run.sv
`timescale 1ns/1ps
`default_nettype none
module t1flp_ones_run
   import t1flp_pkg::*;
#(
   parameter int unsigned RUN_W = 3
)(
   input  wire logic             mclk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             step_in,
   input  wire logic             bit_in,
   output logic      [RUN_W-1:0] run_out
);
   import t1flp_pkg::*;

   localparam logic [RUN_W-1:0] RUN_SAT = RUN_W'(STUFF_RUN + 1);

   logic [RUN_W-1:0] run;
   logic [RUN_W-1:0] next_run;

   // saturates at six so "six or more" stays distinguishable from five
   always_comb
   begin
      next_run = run;
      if (step_in)
      begin
         if (!bit_in)
            next_run = '0;
         else if (run != RUN_SAT)
            next_run = run + RUN_W'(1);
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         run <= '0;
      else
         run <= next_run;
   end

   assign run_out = run;
endmodule
`default_nettype wire

// File: t1flp_pkg.sv
// Summary of operation
// RL1: link bits shift one by one into the 8-bit receive register, first bit LSB.
// RL2: a byte completes every 8 link bits and sets the receive-full flag.
// RL3: receive-full flag with its mask bit enabled pulls the interrupt low.
// RL4: host reads each received byte before the next byte overwrites it.
// RL5: a byte equal to either match byte sets the match flag, maskable interrupt.
// RL6: with destuff enabled, a zero after exactly five ones is dropped.
// RL7: a zero after six or more ones is kept, so flags and aborts pass.
// RL8: host should enable destuffing whenever the data link is extracted.
// RL9: transmit byte is sent LSB first into the framer's link bit slots.
// RL10: after eight bits are sent the transmit-empty flag is set, maskable interrupt.
// RL11: if no new byte is written, the previous byte is sent again.
// RL12: with stuffing enabled, a zero is inserted after five consecutive ones.
// RL13: host should enable stuffing whenever the data link is inserted.
// RL14: for Fs insertion host loads 1Ch, selects register source, enables boundary load.
// RL15: slc-96 message fields pass through the same receive and transmit byte registers.
// RL16: transmit byte is captured at each byte boundary; mid-byte writes wait.
package t1flp_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] REG_RX_BYTE   = 8'hc0;
   localparam logic [7:0] REG_TX_BYTE   = 8'hc1;
   localparam logic [7:0] REG_MATCH_ONE = 8'hc2;
   localparam logic [7:0] REG_MATCH_TWO = 8'hc3;
   localparam logic [7:0] REG_STATUS    = 8'hd0;
   localparam logic [7:0] REG_MASK      = 8'hd1;
   localparam logic [7:0] REG_RX_CTRL2  = 8'hd2;
   localparam logic [7:0] REG_TX_CTRL2  = 8'hd3;
   localparam logic [7:0] REG_TX_CTRL1  = 8'hd4;
   localparam int unsigned ST_MATCH   = 1;
   localparam int unsigned ST_TXEMPTY = 2;
   localparam int unsigned ST_RXFULL  = 3;
   localparam int unsigned RC2_DESTUFF = 3;
   localparam int unsigned TC2_STUFF   = 5;
   localparam int unsigned TC2_MFLOAD  = 6;
   localparam int unsigned TC1_FS_SRC  = 2;
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [7:0] FLAG_MASK   = 8'h0e;
   localparam logic [7:0] RC2_MASK    = 8'h08;
   localparam logic [7:0] TC2_MASK    = 8'h60;
   localparam logic [7:0] TC1_MASK    = 8'h04;
   localparam logic [7:0] FS_PATTERN  = 8'h1c;
   localparam int unsigned BITS_PER_BYTE = 8;
   localparam int unsigned STUFF_RUN     = 5;
   localparam int unsigned LINK_BIT_US   = 250;
   localparam int unsigned BYTE_TIME_US  = BITS_PER_BYTE * LINK_BIT_US;

   typedef struct packed {
      logic strobe;
      logic value;
   } t1flp_bit_t;
endpackage

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import t1flp_pkg::*;
   logic       mclk_in;
   logic       sys_rst_in = 1'b1;
   logic [7:0] addr_in = '0;
   logic [7:0] wdata_in = '0;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic [7:0] rdata_out;
   t1flp_bit_t rx_link;
   t1flp_bit_t tx_link;
   logic       tx_req;
   logic       tx_mf;
   logic       fs_src;
   logic       int_n;
   int         fail_count = 0;
   int         checks = 0;
   logic [15:0] g;
   logic [15:0] g2;
   t1flp_link_port u_t1flp_link_port (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .rx_link_in(rx_link), .tx_req_in(tx_req),
      .tx_mf_boundary_in(tx_mf), .tx_link_out(tx_link), .tx_fs_from_byte_out(fs_src),
      .int_n_out(int_n));
   t1flp_line_model u_t1flp_line_model (.mclk_in(mclk_in), .tx_link_in(tx_link),
      .rx_link_out(rx_link), .tx_req_out(tx_req), .tx_mf_out(tx_mf));
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic complete_run();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t value got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t pin got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      // answer stands only in the cycle after the strobe
      #1;
      cmp_val({8'h00, rdata_out}, {8'h00, exp});
   endtask
   task automatic t_regs();
      chk_reg(REG_RX_BYTE, 8'h00);
      wr(REG_TX_BYTE, 8'h96);
      chk_reg(REG_TX_BYTE, 8'h96);
      wr(REG_RX_BYTE, 8'hff);
      chk_reg(REG_RX_BYTE, 8'h00);
      chk_reg(8'h00, 8'h00);
      cmp_pin(int_n, 1'b1);
      cmp_pin(fs_src, 1'b1);
   endtask
   task automatic t_rx_match();
      wr(REG_MASK, 8'h0e);
      wr(REG_MATCH_ONE, 8'ha5);
      wr(REG_MATCH_TWO, 8'h3c);
      u_t1flp_line_model.send_bits(16'h00a5, 8);
      chk_reg(REG_RX_BYTE, 8'ha5);
      chk_reg(REG_STATUS, 8'h0a);
      cmp_pin(int_n, 1'b0);
      wr(REG_MASK, 8'h00);
      cmp_pin(int_n, 1'b1);
      wr(REG_STATUS, 8'h0e);
      u_t1flp_line_model.send_bits(16'h003c, 8);
      chk_reg(REG_STATUS, 8'h0a);
      wr(REG_STATUS, 8'h0e);
      // host too slow: the next byte simply replaces the old one
      u_t1flp_line_model.send_bits(16'h0041, 8);
      chk_reg(REG_RX_BYTE, 8'h41);
      chk_reg(REG_STATUS, 8'h08);
   endtask
   task automatic t_destuff();
      wr(REG_RX_CTRL2, 8'h08);
      u_t1flp_line_model.send_bits(16'h015f, 9);
      chk_reg(REG_RX_BYTE, 8'hbf);
      u_t1flp_line_model.send_bits(16'h003f, 8);
      chk_reg(REG_RX_BYTE, 8'h3f);
   endtask
   task automatic t_tx();
      wr(REG_MASK, 8'h04);
      wr(REG_STATUS, 8'h0e);
      wr(REG_TX_BYTE, 8'hb4);
      u_t1flp_line_model.pull_bits(8, g);
      cmp_val(g, 16'h00b4);
      chk_reg(REG_STATUS, 8'h04);
      cmp_pin(int_n, 1'b0);
      u_t1flp_line_model.pull_bits(4, g);
      wr(REG_TX_BYTE, 8'h5a);
      u_t1flp_line_model.pull_bits(12, g2);
      cmp_val({g2[11:0], g[3:0]}, 16'h5ab4);
   endtask
   task automatic t_stuff_fs();
      wr(REG_TX_CTRL2, 8'h20);
      wr(REG_TX_BYTE, 8'hff);
      u_t1flp_line_model.pull_bits(9, g);
      cmp_val(g, 16'h01df);
      wr(REG_TX_CTRL1, 8'h04);
      cmp_pin(fs_src, 1'b0);
      wr(REG_TX_CTRL1, 8'h00);
      cmp_pin(fs_src, 1'b1);
      wr(REG_TX_CTRL2, 8'h40);
      wr(REG_TX_BYTE, FS_PATTERN);
      u_t1flp_line_model.pull_bits(3, g);
      u_t1flp_line_model.mf_pulse();
      u_t1flp_line_model.pull_bits(8, g);
      cmp_val(g, 16'h001c);
   endtask
   initial
   begin
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_rx_match();
      t_destuff();
      t_tx();
      t_stuff_fs();
      complete_run();
   end
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire
